// ---- rtl/pos_scale_pkg.sv ----
package pos_scale_pkg;

    // ------------------------------------------------------------------
    // register map (word-aligned byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG    = 8'h00;
    localparam logic [7:0] ADDR_MULT      = 8'h04;
    localparam logic [7:0] ADDR_DIV       = 8'h08;
    localparam logic [7:0] ADDR_PRESET    = 8'h0c;
    localparam logic [7:0] ADDR_COMMIT    = 8'h10;
    localparam logic [7:0] ADDR_CONTROL   = 8'h14;
    localparam logic [7:0] ADDR_STATUS    = 8'h18;
    localparam logic [7:0] ADDR_POSITION  = 8'h1c;
    localparam logic [7:0] ADDR_VELOCITY  = 8'h20;
    localparam logic [7:0] ADDR_OFFSET    = 8'h24;

    // ------------------------------------------------------------------
    // config fields
    // ------------------------------------------------------------------
    localparam int CFG_GRAY_BIT    = 0;
    localparam int CFG_NEGLOGIC_BIT = 1;
    localparam int CFG_NEGDIR_BIT  = 2;
    localparam int CFG_VEL60_BIT   = 3;
    localparam int CTRL_APPLY_BIT  = 0;

    // ------------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------------
    localparam logic [15:0] SCALE_MIN      = 16'h0001;
    localparam logic [15:0] SCALE_MAX      = 16'h7fff;
    localparam logic [15:0] MULT_RESET     = 16'h0001;
    localparam logic [15:0] DIV_RESET      = 16'h0001;
    localparam logic [31:0] PRESET_RESET   = 32'h0000_0000;
    localparam logic [3:0]  CFG_RESET      = 4'h0;
    localparam logic [3:0]  ERR_NONE       = 4'h0;
    localparam logic [3:0]  ERR_MULT_RANGE = 4'h6;
    localparam logic [3:0]  ERR_DIV_RANGE  = 4'h7;
    localparam logic [3:0]  ERR_MULT_GT_DIV = 4'h8;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLOCK_HZ        = 200_000_000;
    localparam int VEL_SHORT_MS    = 60;
    localparam int VEL_LONG_MS     = 160;
    localparam int VEL_SHORT_CYC   = CLOCK_HZ / 1000 * VEL_SHORT_MS;
    localparam int VEL_LONG_CYC    = CLOCK_HZ / 1000 * VEL_LONG_MS;
    localparam int DIV_CYC         = 48;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DIV   = 2'b01,
        ST_DONE  = 2'b10
    } scale_state_t;

endpackage

// ---- rtl/pos_divider.sv ----
`timescale 1ns/100ps
`default_nettype none
module pos_divider
    import pos_scale_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  wire logic [47:0] dividend,
    input  wire logic [15:0] divisor,
    output logic             done,
    output logic      [47:0] quotient
);
    logic [47:0] rem_q;
    logic [47:0] num;
    logic [5:0]  count;
    logic        busy;
    logic [48:0] trial;

    always_comb
    begin
        trial = {rem_q, num[47]} - {33'h0, divisor};
    end

    // ------------------------------------------------------------------
    // restoring divide, one bit per cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rem_q    <= 48'h0;
            num      <= 48'h0;
            quotient <= 48'h0;
            count    <= 6'h0;
            busy     <= 1'b0;
            done     <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                rem_q <= 48'h0;
                num   <= dividend;
                count <= 6'(DIV_CYC);
                busy  <= 1'b1;
            end
            else if (busy)
            begin
                if (!trial[48])
                    rem_q <= trial[47:0];
                else
                    rem_q <= {rem_q[46:0], num[47]};
                num      <= {num[46:0], 1'b0};
                quotient <= {quotient[46:0], ~trial[48]};
                count    <= count - 6'h1;
                if (count == 6'h1)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ssi_position_scaling.sv ----
// Overview of operation
// - multiplier and divisor accept 1..32767 only, both reset to one
// - raw word is multiplied by multiplier and divided by divisor
// - writing preset leaves position unchanged until apply bit rises
// - on apply, reported position becomes the stored preset; skipped until a word is decoded after reset
// - apply creates an offset added to every later position
// - offset is kept in a retained store across power loss
// - committing full setup clears any applied offset
// - negative direction negates the position before reporting
// - direction resets to positive, which passes value unchanged
// - velocity refreshes every 60 ms or 160 ms, default 160 ms
// - velocity interval does not change position refresh rate
// - velocity is in counts per second
// - negative data logic inverts raw bits before decoding
// - gray code raw word is converted to binary, binary by default
// - setup with multiplier above divisor is refused, error 8
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module ssi_position_scaling
    import pos_scale_pkg::*;
#(
    parameter int VEL_SHORT = VEL_SHORT_CYC,
    parameter int VEL_LONG  = VEL_LONG_CYC
)
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [31:0] raw_word,
    input  wire logic        raw_valid,
    input  wire logic [31:0] nv_offset,
    input  wire logic        nv_valid,
    output logic      [31:0] nv_wdata,
    output logic             nv_write,
    output logic      [31:0] position,
    output logic             position_valid,
    output logic      [31:0] velocity,
    output logic             velocity_valid,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [3:0]  cfg_stage;
    logic [15:0] mult_stage;
    logic [15:0] div_stage;
    logic [31:0] preset_stage;
    logic [3:0]  cfg;
    logic [15:0] mult;
    logic [15:0] divisor;
    logic [31:0] preset;
    logic        apply_bit;
    logic        apply_prev;
    logic [3:0]  err_code;
    logic [31:0] offset;
    logic        nv_seen;
    logic        bus_req;
    logic        bus_wr;
    logic [31:0] wmask;
    logic [31:0] next_word;
    logic        commit_req;
    logic        apply_evt;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i;
    assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~wmask) | (wb_dat_i & wmask);
    endfunction

    assign commit_req = bus_wr && (wb_adr_i == ADDR_COMMIT);

    always_comb
    begin
        case (wb_adr_i)
            ADDR_CONFIG: next_word = merge({28'h0, cfg_stage});
            ADDR_MULT:   next_word = merge({16'h0, mult_stage});
            ADDR_DIV:    next_word = merge({16'h0, div_stage});
            default:     next_word = merge(preset_stage);
        endcase
    end

    // ------------------------------------------------------------------
    // staging registers written by software
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_stage    <= CFG_RESET;
            mult_stage   <= MULT_RESET;
            div_stage    <= DIV_RESET;
            preset_stage <= PRESET_RESET;
            apply_bit    <= 1'b0;
        end
        else if (bus_wr)
        begin
            case (wb_adr_i)
                ADDR_CONFIG:  cfg_stage    <= next_word[3:0];
                ADDR_MULT:    mult_stage   <= next_word[15:0];
                ADDR_DIV:     div_stage    <= next_word[15:0];
                ADDR_PRESET:  preset_stage <= next_word;
                ADDR_CONTROL:
                    if (wb_sel_i[0])
                        apply_bit <= wb_dat_i[CTRL_APPLY_BIT];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // setup commit with checks
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg      <= CFG_RESET;
            mult     <= MULT_RESET;
            divisor  <= DIV_RESET;
            preset   <= PRESET_RESET;
            err_code <= ERR_NONE;
        end
        else if (commit_req)
        begin
            if (mult_stage < SCALE_MIN || mult_stage > SCALE_MAX)
                err_code <= ERR_MULT_RANGE;
            else if (div_stage < SCALE_MIN || div_stage > SCALE_MAX)
                err_code <= ERR_DIV_RANGE;
            else if (mult_stage > div_stage)
                err_code <= ERR_MULT_GT_DIV;
            else
            begin
                err_code <= ERR_NONE;
                cfg      <= cfg_stage;
                mult     <= mult_stage;
                divisor  <= div_stage;
                preset   <= preset_stage;
            end
        end
    end

    // ------------------------------------------------------------------
    // raw decode: inversion, gray, scaling
    // ------------------------------------------------------------------
    logic [31:0] inv_word;
    logic [31:0] bin_word;
    logic [31:0] raw_hold;
    logic        div_start;
    logic        div_done;
    logic [47:0] quotient;
    logic [31:0] scaled;
    logic [31:0] directed;
    logic        scaled_ready;

    assign inv_word = cfg[CFG_NEGLOGIC_BIT] ? ~raw_word : raw_word;

    always_comb
    begin
        bin_word[31] = inv_word[31];
        for (int i = 30; i >= 0; i--)
            bin_word[i] = cfg[CFG_GRAY_BIT] ?
                          (bin_word[i + 1] ^ inv_word[i]) : inv_word[i];
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            raw_hold  <= 32'h0;
            div_start <= 1'b0;
        end
        else
        begin
            div_start <= raw_valid;
            if (raw_valid)
                raw_hold <= bin_word;
        end
    end

    pos_divider u_div (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .start    (div_start),
        .dividend (48'(raw_hold) * 48'(mult)),
        .divisor  (divisor),
        .done     (div_done),
        .quotient (quotient)
    );

    assign directed = cfg[CFG_NEGDIR_BIT] ? 32'(-quotient[31:0])
                                          : quotient[31:0];

    // ------------------------------------------------------------------
    // offset and preset apply
    // ------------------------------------------------------------------
    assign apply_evt = apply_bit && !apply_prev;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            apply_prev <= 1'b0;
            offset     <= 32'h0;
            nv_seen    <= 1'b0;
            nv_write   <= 1'b0;
            nv_wdata   <= 32'h0;
            scaled     <= 32'h0;
        end
        else
        begin
            apply_prev <= apply_bit;
            nv_write   <= 1'b0;
            if (div_done)
                scaled <= directed;
            if (nv_valid && !nv_seen)
            begin
                nv_seen <= 1'b1;
                offset  <= nv_offset;
            end
            else if (commit_req
                     && mult_stage <= div_stage && mult_stage >= SCALE_MIN
                     && mult_stage <= SCALE_MAX && div_stage >= SCALE_MIN
                     && div_stage <= SCALE_MAX)
            begin
                offset   <= 32'h0;
                nv_wdata <= 32'h0;
                nv_write <= 1'b1;
            end
            else if (apply_evt)
            begin
                offset   <= preset - scaled;
                nv_wdata <= preset - scaled;
                nv_write <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // reported position, refreshed on each divide started by a word arriving while the divider is idle
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            position       <= 32'h0;
            position_valid <= 1'b0;
            scaled_ready   <= 1'b0;
        end
        else
        begin
            position_valid <= div_done;
            if (div_done)
            begin
                position     <= directed + offset;
                scaled_ready <= 1'b1;
            end
            else if (apply_evt && scaled_ready)
                position <= preset;
        end
    end

    // ------------------------------------------------------------------
    // velocity in counts per second
    // ------------------------------------------------------------------
    logic [31:0] vel_timer;
    logic [31:0] vel_last;
    logic [31:0] delta;
    logic [31:0] vel_limit;

    assign vel_limit = cfg[CFG_VEL60_BIT] ? 32'(VEL_SHORT - 1)
                                          : 32'(VEL_LONG - 1);
    assign delta     = position - vel_last;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            vel_timer      <= 32'h0;
            vel_last       <= 32'h0;
            velocity       <= 32'h0;
            velocity_valid <= 1'b0;
        end
        else
        begin
            velocity_valid <= 1'b0;
            if (vel_timer >= vel_limit)
            begin
                vel_timer      <= 32'h0;
                vel_last       <= position;
                velocity_valid <= 1'b1;
                if (cfg[CFG_VEL60_BIT])
                    velocity <= 32'((64'($signed(delta)) * 50) / 3);
                else
                    velocity <= 32'((64'($signed(delta)) * 25) / 4);
            end
            else
                vel_timer <= vel_timer + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // wishbone read and ack
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
            begin
                case (wb_adr_i)
                    ADDR_CONFIG:   wb_dat_o <= {28'h0, cfg_stage};
                    ADDR_MULT:     wb_dat_o <= {16'h0, mult_stage};
                    ADDR_DIV:      wb_dat_o <= {16'h0, div_stage};
                    ADDR_PRESET:   wb_dat_o <= preset_stage;
                    ADDR_CONTROL:  wb_dat_o <= {31'h0, apply_bit};
                    ADDR_STATUS:   wb_dat_o <= {28'h0, err_code};
                    ADDR_POSITION: wb_dat_o <= position;
                    ADDR_VELOCITY: wb_dat_o <= velocity;
                    ADDR_OFFSET:   wb_dat_o <= offset;
                    default:       wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/ssi_position_scaling_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssi_position_scaling_checker
#(
    parameter int VEL_SHORT = 60,
    parameter int VEL_LONG  = 160
)
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        raw_valid,
    input wire logic        position_valid,
    input wire logic        velocity_valid,
    input wire logic        nv_write,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o
);
    logic [31:0] gap;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // cycles since the last velocity update
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            gap <= 32'h0;
        else if (velocity_valid)
            gap <= 32'h0;
        else
            gap <= gap + 32'h1;
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    a_ack_latency: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_ack_cause: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_rdata_hold: assert property (
        $changed(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i && !wb_we_i))
        else $error("read data moved");
    a_pos_latency: assert property (
        raw_valid |-> ##[1:64] position_valid)
        else $error("position not reported");
    a_vel_bound: assert property (
        gap <= 32'(VEL_LONG + VEL_SHORT))
        else $error("velocity update missing");
    a_vel_pulse: assert property (
        velocity_valid |=> !velocity_valid)
        else $error("velocity strobe held");
    a_nv_pulse: assert property (
        nv_write |=> !nv_write)
        else $error("store write held");

    c_position: cover property (raw_valid ##[1:64] position_valid);
    c_velocity: cover property (velocity_valid);
    c_store: cover property (nv_write);
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule
`default_nettype wire

// ---- dv/nv_store_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module nv_store_model
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [31:0] nv_wdata,
    input  wire logic        nv_write,
    output logic      [31:0] nv_offset,
    output logic             nv_valid
);
    logic [31:0] store = 32'h0;
    logic [1:0]  boot;

    // retained value, untouched by reset
    always @(posedge clock)
    begin
        if (nv_write)
            store <= nv_wdata;
    end

    // one restore pulse after each reset release
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            boot <= 2'h0;
        else if (boot != 2'h3)
            boot <= boot + 2'h1;
    end

    assign nv_valid  = (boot == 2'h2);
    assign nv_offset = nv_valid ? store : ~store;
endmodule
`default_nettype wire

// ---- dv/tb_ssi_position_scaling.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_ssi_position_scaling
    import pos_scale_pkg::*;
;
    localparam int VS = 60;
    localparam int VL = 160;
    logic        clock, sys_rst, raw_valid, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [31:0] raw_word, wb_dat_i, wb_dat_o, nv_offset, nv_wdata, raw_next;
    logic [31:0] position, velocity, q, m_pre, m_off, m_last;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, m_cfg;
    logic [15:0] m_mult, m_div, ml, dv;
    logic        nv_valid, nv_write, position_valid, velocity_valid;
    logic        wb_ack_o;
    int          err_count, checked, n;

    ssi_position_scaling #(.VEL_SHORT(VS), .VEL_LONG(VL)) u_dut
    (
        .clock         (clock),
        .sys_rst       (sys_rst),
        .raw_word      (raw_word),
        .raw_valid     (raw_valid),
        .nv_offset     (nv_offset),
        .nv_valid      (nv_valid),
        .nv_wdata      (nv_wdata),
        .nv_write      (nv_write),
        .position      (position),
        .position_valid(position_valid),
        .velocity      (velocity),
        .velocity_valid(velocity_valid),
        .wb_cyc_i      (wb_cyc_i),
        .wb_stb_i      (wb_stb_i),
        .wb_we_i       (wb_we_i),
        .wb_adr_i      (wb_adr_i),
        .wb_sel_i      (wb_sel_i),
        .wb_dat_i      (wb_dat_i),
        .wb_dat_o      (wb_dat_o),
        .wb_ack_o      (wb_ack_o)
    );

    nv_store_model u_store
    (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .nv_wdata (nv_wdata),
        .nv_write (nv_write),
        .nv_offset(nv_offset),
        .nv_valid (nv_valid)
    );

    always #2.5 clock = ~clock;

    // ------------------------------------------------------------------
    // model and helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] scaled(input logic [31:0] r);
        logic [31:0] b;
        logic [63:0] s;
        b = m_cfg[CFG_NEGLOGIC_BIT] ? ~r : r;
        if (m_cfg[CFG_GRAY_BIT])
            for (int i = 30; i >= 0; i--) b[i] = b[i + 1] ^ b[i];
        s = ({32'h0, b} * m_mult) / m_div;
        return m_cfg[CFG_NEGDIR_BIT] ? -s[31:0] : s[31:0];
    endfunction

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(logic [7:0] a, logic we, logic [31:0] d);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50)
            check("bus ack", 32'h0, 32'h1);
    endtask

    task automatic rd_chk(logic [7:0] a, logic [31:0] e, string nm);
        wb(a, 1'b0, 32'h0);
        check(nm, q, e);
    endtask

    task automatic feed(logic [31:0] r);
        @(posedge clock);
        raw_word  <= r;
        raw_valid <= 1'b1;
        m_last = scaled(r);
        @(posedge clock);
        raw_valid <= 1'b0;
        raw_word  <= ~r;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end while (position_valid !== 1'b1 && n < 100);
        check("position", position, m_last + m_off);
        repeat (8) @(posedge clock);
    endtask

    task automatic setup(logic [3:0] c, logic [15:0] m, logic [15:0] d,
                         logic [31:0] p, logic [3:0] e);
        wb(ADDR_CONFIG, 1'b1, {28'h0, c});
        wb(ADDR_MULT, 1'b1, {16'h0, m});
        wb(ADDR_DIV, 1'b1, {16'h0, d});
        wb(ADDR_PRESET, 1'b1, p);
        wb(ADDR_COMMIT, 1'b1, 32'h1);
        rd_chk(ADDR_STATUS, {28'h0, e}, "status");
        if (e == ERR_NONE)
        begin
            m_cfg  = c;
            m_mult = m;
            m_div  = d;
            m_pre  = p;
            m_off  = 32'h0;
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        clock = 1'b0; sys_rst = 1'b1; raw_word = 32'h0; raw_valid = 1'b0;
        wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
        wb_adr_i = 8'h0; wb_sel_i = 4'hf; wb_dat_i = 32'h0;
        m_cfg = CFG_RESET; m_mult = MULT_RESET; m_div = DIV_RESET;
        m_off = 32'h0; m_pre = PRESET_RESET;
        void'($urandom(32'h9551a1a7));
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        rd_chk(ADDR_MULT, 32'h1, "mult");
        rd_chk(ADDR_DIV, 32'h1, "div");
        rd_chk(ADDR_CONFIG, 32'h0, "config");
        rd_chk(8'h3c, 32'h0, "unmapped");
        wb(8'h3c, 1'b1, $urandom());
        feed($urandom());
        $display("test defaults done");
        for (int c = 0; c < 16; c++)
        begin
            dv = 16'($urandom_range(32767, 1));
            ml = 16'($urandom_range(dv, 1));
            setup(4'(c), ml, dv, 32'h0, ERR_NONE);
            feed($urandom());
            feed($urandom());
        end
        setup(4'h0, 16'h0, 16'h1, 32'h0, ERR_MULT_RANGE);
        setup(4'h0, 16'h1, 16'h8000, 32'h0, ERR_DIV_RANGE);
        setup(4'h0, 16'h5, 16'h4, 32'h0, ERR_MULT_GT_DIV);
        feed($urandom());
        setup(4'h0, SCALE_MAX, SCALE_MAX, 32'h0, ERR_NONE);
        feed(32'hffff_ffff);
        $display("test scaling done");
        setup(4'h4, 16'd50, 16'd127, $urandom(), ERR_NONE);
        feed($urandom());
        wb(ADDR_CONTROL, 1'b1, 32'h1);
        m_off = m_pre - m_last;
        repeat (2) @(posedge clock);
        check("preset", position, m_pre);
        rd_chk(ADDR_OFFSET, m_off, "offset");
        wb(ADDR_CONTROL, 1'b1, 32'h0);
        feed($urandom());
        sys_rst <= 1'b1;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        m_cfg = CFG_RESET; m_mult = MULT_RESET; m_div = DIV_RESET;
        repeat (4) @(posedge clock);
        feed($urandom());
        setup(4'h0, 16'h5, 16'h4, 32'h0, ERR_MULT_GT_DIV);
        setup(4'h0, 16'h1, 16'h1, 32'h0, ERR_NONE);
        feed($urandom());
        $display("test preset done");
        for (int v = 0; v < 2; v++)
        begin
            setup(v ? 4'h8 : 4'h0, 16'h1, 16'h1, 32'h0, ERR_NONE);
            feed($urandom());
            for (int k = 0; k < 2; k++)
            begin
                n = 0;
                do
                begin
                    @(posedge clock);
                    n++;
                end while (velocity_valid !== 1'b1 && n < 400);
            end
            check("interval", 32'(n), 32'(v ? VS : VL));
            check("velocity", velocity, 32'h0);
            q = position;
            raw_next = $urandom();
            m_last = scaled(raw_next);
            raw_word  <= raw_next;
            raw_valid <= 1'b1;
            @(posedge clock);
            raw_valid <= 1'b0;
            n = 0;
            do
            begin
                @(posedge clock);
                n++;
            end while (velocity_valid !== 1'b1 && n < 400);
            check("position", position, m_last + m_off);
            q = 32'(longint'(signed'(m_last + m_off - q)) * 1000
                    / (v ? VEL_SHORT_MS : VEL_LONG_MS));
            check("velocity", velocity, q);
        end
        $display("test velocity done");
        finish_test;
    end

    initial
    begin
        repeat (40000) @(posedge clock);
        err_count++;
        $display("watchdog expired");
        finish_test;
    end
endmodule

bind ssi_position_scaling ssi_position_scaling_checker
#(
    .VEL_SHORT(VEL_SHORT),
    .VEL_LONG (VEL_LONG)
)
u_chk
(
    .clock         (clock),
    .sys_rst       (sys_rst),
    .raw_valid     (raw_valid),
    .position_valid(position_valid),
    .velocity_valid(velocity_valid),
    .nv_write      (nv_write),
    .wb_cyc_i      (wb_cyc_i),
    .wb_stb_i      (wb_stb_i),
    .wb_we_i       (wb_we_i),
    .wb_dat_o      (wb_dat_o),
    .wb_ack_o      (wb_ack_o)
);
`default_nettype wire
